// ===== ffs_pkg.sv
`default_nettype none
package ffs_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned SENSE_QUAL_MS = 800;
	localparam int unsigned SEC_MS        = 1000;
	localparam int unsigned SENSE_QUAL_CYC = CLK_HZ / 1000 * SENSE_QUAL_MS;
	localparam int unsigned SEC_CYC        = CLK_HZ / 1000 * SEC_MS;
	localparam int          CNT_W          = 26;
	localparam int          VAL_W          = 10;
	// arc voltage in 0.1 V steps
	localparam logic [VAL_W-1:0] SENSE_MIN_DV = 10'h050;
	localparam logic [4:0]       OVL_START_S  = 5'h1e;
	localparam logic [4:0]       OVL_END_S    = 5'h00;
	localparam logic [2:0]       ACC_MIN      = 3'h1;
	localparam logic [2:0]       ACC_MAX      = 3'h5;

	typedef enum logic [2:0] {
		FFS_DC_NUM   = 3'h0,
		FFS_DC_BLANK = 3'h1,
		FFS_DC_HOLD  = 3'h2,
		FFS_DC_GLP   = 3'h3,
		FFS_DC_ACC   = 3'h4,
		FFS_DC_SEC   = 3'h5,
		FFS_DC_CLD   = 3'h6,
		FFS_DC_ERR   = 3'h7
	} ffs_disp_code_e;

	typedef struct packed {
		ffs_disp_code_e   code;
		logic [VAL_W-1:0] val;
	} ffs_disp_s;

	typedef struct packed {
		logic trig;
		logic ovl;
		logic gnd;
		logic key;
	} ffs_pin_s;

	typedef struct packed {
		ffs_pin_s         s1;
		ffs_pin_s         s2;
		logic             trig_d;
		logic             key_d;
		logic [CNT_W-1:0] lv_cnt;
		logic             vsl;
		logic             ovl;
		logic [4:0]       ovl_s;
		logic             gnd;
		logic             gnd_rel;
		logic             err;
		logic [CNT_W-1:0] sec_cnt;
		logic             pf_on;
		logic [7:0]       pf_s;
		logic             motor_fwd;
		logic             motor_rev;
		logic             gas;
		logic             ps_en;
		logic             ps_trig;
		logic [VAL_W-1:0] cmd_volt;
		logic [VAL_W-1:0] cmd_wfs;
		ffs_disp_s        disp_wfs;
		ffs_disp_s        disp_volt;
	} ffs_state_s;
endpackage : ffs_pkg
`default_nettype wire

// ===== ffs_supervisor.sv
`default_nettype none
module ffs_supervisor
	import ffs_pkg::*;
#(
	parameter int unsigned SENSE_QUAL_CYCLES = SENSE_QUAL_CYC,
	parameter int unsigned SEC_CYCLES        = SEC_CYC
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	// pins from gun, motor sensor, frame detector, keypad
	input  wire ffs_pin_s         pins_i,
	// measurements and settings (controller domain)
	input  wire logic [VAL_W-1:0] arc_volt_i,
	input  wire logic             cold_fwd_i,
	input  wire logic             cold_rev_i,
	input  wire logic             cold_mode_i,
	input  wire logic             acc_setup_i,
	input  wire logic [2:0]       acc_set_i,
	input  wire logic             timer_show_i,
	input  wire logic [VAL_W-1:0] timer_val_i,
	input  wire logic             runin_phase_i,
	input  wire logic             runin_match_i,
	input  wire logic [VAL_W-1:0] weld_volt_i,
	input  wire logic [VAL_W-1:0] weld_wfs_i,
	input  wire logic [VAL_W-1:0] runin_volt_i,
	input  wire logic [VAL_W-1:0] runin_wfs_i,
	input  wire logic [7:0]       postflow_s_i,
	input  wire logic             nv_check_i,
	input  wire logic             nv_bad_i,
	// drives
	output logic                  motor_fwd_o,
	output logic                  motor_rev_o,
	output logic                  gas_on_o,
	output logic                  ps_enable_o,
	output logic                  ps_trig_o,
	output logic [VAL_W-1:0]      cmd_volt_o,
	output logic [VAL_W-1:0]      cmd_wfs_o,
	// displays
	output ffs_disp_s             wire_feed_speed_display_o,
	output ffs_disp_s             volt_display_o
);
	ffs_state_s r;
	ffs_state_s n;
	logic       trig;
	logic       key_edge;
	logic       trig_fall;
	logic       tick;
	logic       fault;
	logic       weld;
	logic       cold_mtr;
	logic [2:0] acc_lim;

	always_comb begin
		n = r;
		n.s1 = pins_i;
		n.s2 = r.s1;
		trig = r.s2.trig;
		n.trig_d = trig;
		n.key_d = r.s2.key;
		key_edge = r.s2.key & ~r.key_d;
		trig_fall = r.trig_d & ~trig;
		tick = (r.sec_cnt == CNT_W'(SEC_CYCLES - 1));
		fault = r.vsl | r.ovl | r.gnd;
		// a cold feed key or cold mode keeps weld output off even with the trigger closed
		weld = trig & ~cold_mode_i & ~cold_fwd_i & ~cold_rev_i & ~fault;
		cold_mtr = cold_fwd_i | (cold_mode_i & trig);

		// timer runs only while welding: with output off the sensed voltage is zero anyway
		if (weld && arc_volt_i < SENSE_MIN_DV) begin
			if (r.lv_cnt != CNT_W'(SENSE_QUAL_CYCLES))
				n.lv_cnt = r.lv_cnt + 1'b1;
		end else begin
			n.lv_cnt = '0;
		end
		if (!trig)
			n.vsl = 1'b0;
		else if (r.lv_cnt == CNT_W'(SENSE_QUAL_CYCLES))
			n.vsl = 1'b1;

		// restarting the timebase makes the first count step a full second
		if ((r.s2.ovl && !r.ovl) || trig_fall || tick)
			n.sec_cnt = '0;
		else
			n.sec_cnt = r.sec_cnt + 1'b1;

		if (r.s2.ovl && !r.ovl) begin
			n.ovl = 1'b1;
			n.ovl_s = OVL_START_S;
		end else if (r.ovl && tick) begin
			n.ovl_s = r.ovl_s - 1'b1;
			if (r.ovl_s - 1'b1 == OVL_END_S)
				n.ovl = 1'b0;
		end

		if (r.gnd) begin
			if (r.gnd_rel && (key_edge || trig)) begin
				n.gnd = 1'b0;
				n.gnd_rel = 1'b0;
			end else if (!trig) begin
				n.gnd_rel = 1'b1;
			end
		end
		// detector wins over a clear in the same cycle
		if (r.s2.gnd) begin
			n.gnd = 1'b1;
			n.gnd_rel = 1'b0;
		end

		if (nv_check_i && nv_bad_i)
			n.err = 1'b1;
		else if (key_edge)
			n.err = 1'b0;

		if (weld || fault) begin
			n.pf_on = 1'b0;
		end else if (trig_fall && r.ps_en && postflow_s_i != 8'h00) begin
			n.pf_on = 1'b1;
			n.pf_s = postflow_s_i;
		end else if (r.pf_on && tick) begin
			n.pf_s = r.pf_s - 1'b1;
			if (r.pf_s == 8'h01)
				n.pf_on = 1'b0;
		end

		n.motor_fwd = ~fault & (weld | cold_mtr);
		n.motor_rev = ~fault & cold_rev_i & ~cold_mtr;
		// next postflow state bridges the release cycle so gas never blinks off
		n.gas = ~fault & (weld | r.pf_on | n.pf_on);
		n.ps_en = weld;
		n.ps_trig = weld & ~r.gnd;
		n.cmd_volt = (runin_phase_i && !runin_match_i) ? runin_volt_i : weld_volt_i;
		n.cmd_wfs = (runin_phase_i && !runin_match_i) ? runin_wfs_i : weld_wfs_i;

		acc_lim = acc_set_i < ACC_MIN ? ACC_MIN : (acc_set_i > ACC_MAX ? ACC_MAX : acc_set_i);
		n.disp_wfs = '{FFS_DC_NUM, r.cmd_wfs};
		n.disp_volt = '{FFS_DC_NUM, r.cmd_volt};
		if (r.gnd) begin
			n.disp_wfs = '{FFS_DC_GLP, '0};
			n.disp_volt = '{FFS_DC_BLANK, '0};
		end else if (r.ovl) begin
			n.disp_wfs = '{FFS_DC_HOLD, VAL_W'(r.ovl_s)};
			n.disp_volt = '{FFS_DC_BLANK, '0};
		end else if (r.err) begin
			n.disp_wfs = '{FFS_DC_ERR, '0};
			n.disp_volt = '{FFS_DC_BLANK, '0};
		end else if (acc_setup_i) begin
			n.disp_wfs = '{FFS_DC_NUM, VAL_W'(acc_lim)};
			n.disp_volt = '{FFS_DC_ACC, '0};
		end else if (timer_show_i) begin
			n.disp_wfs = '{FFS_DC_SEC, '0};
			n.disp_volt = '{FFS_DC_NUM, timer_val_i};
		end else if (cold_mtr || cold_rev_i || cold_mode_i) begin
			n.disp_volt = '{FFS_DC_CLD, '0};
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			r <= '0;
		else
			r <= n;
	end

	assign motor_fwd_o = r.motor_fwd;
	assign motor_rev_o = r.motor_rev;
	assign gas_on_o = r.gas;
	assign ps_enable_o = r.ps_en;
	assign ps_trig_o = r.ps_trig;
	assign cmd_volt_o = r.cmd_volt;
	assign cmd_wfs_o = r.cmd_wfs;
	assign wire_feed_speed_display_o = r.disp_wfs;
	assign volt_display_o = r.disp_volt;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	a_vsl_entry: assert property (r.s2.trig && r.lv_cnt == CNT_W'(SENSE_QUAL_CYCLES) |=> r.vsl)
		else $error("sense loss not entered");
	a_vsl_hold: assert property (r.vsl && r.s2.trig |=> r.vsl)
		else $error("sense loss dropped with trigger closed");
	a_vsl_outputs: assert property (r.vsl |=> !motor_fwd_o && !gas_on_o && !ps_enable_o)
		else $error("drives on during sense loss");
	a_ovl_show: assert property ($rose(r.ovl) && !r.gnd |=> wire_feed_speed_display_o.code == FFS_DC_HOLD
		&& wire_feed_speed_display_o.val == VAL_W'(OVL_START_S) && volt_display_o.code == FFS_DC_BLANK)
		else $error("overload display wrong");
	a_ovl_count: assert property (r.ovl && tick |=> r.ovl_s == $past(r.ovl_s) - 5'h01)
		else $error("overload count not stepping");
	a_gnd_off: assert property (r.gnd |=> !ps_trig_o && !motor_fwd_o && !gas_on_o
		&& wire_feed_speed_display_o.code == FFS_DC_GLP)
		else $error("ground fault outputs wrong");
	a_gnd_hold: assert property (r.gnd && !r.gnd_rel |=> r.gnd)
		else $error("ground fault cleared before release");
	a_acc_range: assert property (volt_display_o.code == FFS_DC_ACC |-> wire_feed_speed_display_o.val >= VAL_W'(ACC_MIN)
		&& wire_feed_speed_display_o.val <= VAL_W'(ACC_MAX))
		else $error("acceleration out of range");
	a_sec_tag: assert property (timer_show_i && !acc_setup_i && !fault && !r.err |=> wire_feed_speed_display_o.code == FFS_DC_SEC)
		else $error("seconds tag missing");
	a_cold_tag: assert property (volt_display_o.code == FFS_DC_CLD |-> !ps_enable_o)
		else $error("weld output on in cold feed");
	a_err_set: assert property (nv_check_i && nv_bad_i |=> r.err)
		else $error("storage error not latched");
	a_runin_match: assert property (runin_phase_i && runin_match_i |=> cmd_wfs_o == $past(weld_wfs_i))
		else $error("run-in did not use weld value");
	a_postflow_gas: assert property (r.pf_on && !fault |=> gas_on_o)
		else $error("gas off during postflow");
	a_lv_restart: assert property (!r.s2.trig |=> r.lv_cnt == '0)
		else $error("low-voltage timer not restarted");

	c_vsl: cover property ($rose(r.vsl));
	c_ovl_done: cover property ($fell(r.ovl));
	c_gnd_clear: cover property ($fell(r.gnd));
	c_postflow: cover property ($fell(r.pf_on));
endmodule : ffs_supervisor
`default_nettype wire

// ===== ffs_arc_model.sv
`default_nettype none
module ffs_arc_model
	import ffs_pkg::*;
(
	// power source control and a sense-lead fault switch
	input  wire logic             clk_i,
	input  wire logic             out_on_i,
	input  wire logic             sense_ok_i,
	// sensed arc voltage
	output logic      [VAL_W-1:0] arc_volt_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// output off or sense lead open both read as zero volts, as the real leads would
	always @(posedge clk_i) begin
		arc_volt_o <= #2 (out_on_i && sense_ok_i) ? 10'h0f0 : 10'h000;
	end
endmodule : ffs_arc_model
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ffs_pkg::*;
	logic             clk_sys_i = 1'b0;
	logic             nrst_i = 1'b0;
	ffs_pin_s         pins = '0;
	logic [2:0]       cf = 3'h0, acc_set = 3'h0;
	logic             acc_setup = 1'b0, timer_show = 1'b0, rphase = 1'b0, rmatch = 1'b0;
	logic             nv_chk = 1'b0, nv_bad = 1'b0, sok = 1'b1;
	logic [7:0]       pflow = 8'h00;
	logic [VAL_W-1:0] tval = 10'h00c, arc, cv, cw;
	logic [VAL_W-1:0] wv = 10'h0c8, ww = 10'h12c, rv = 10'h0a0, rw = 10'h064;
	logic             mf, mr, gas, pse, pst;
	ffs_disp_s        dw, dv;
	int               bad_count = 0, tests_run = 0, cycles = 0, n;
	wire  [3:0]       drv = {mf, gas, pse, pst};

	always #12.5 clk_sys_i = ~clk_sys_i;

	ffs_supervisor #(.SENSE_QUAL_CYCLES(8), .SEC_CYCLES(16)) dut (
		.clk_sys_i, .nrst_i, .pins_i(pins), .arc_volt_i(arc), .cold_fwd_i(cf[0]), .cold_rev_i(cf[1]),
		.cold_mode_i(cf[2]), .acc_setup_i(acc_setup), .acc_set_i(acc_set), .timer_show_i(timer_show),
		.timer_val_i(tval), .runin_phase_i(rphase), .runin_match_i(rmatch), .weld_volt_i(wv),
		.weld_wfs_i(ww), .runin_volt_i(rv), .runin_wfs_i(rw), .postflow_s_i(pflow),
		.nv_check_i(nv_chk), .nv_bad_i(nv_bad), .motor_fwd_o(mf), .motor_rev_o(mr), .gas_on_o(gas),
		.ps_enable_o(pse), .ps_trig_o(pst), .cmd_volt_o(cv), .cmd_wfs_o(cw),
		.wire_feed_speed_display_o(dw), .volt_display_o(dv));

	ffs_arc_model psrc (.clk_i(clk_sys_i), .out_on_i(pse && pst), .sense_ok_i(sok), .arc_volt_o(arc));

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_i);
		#2;
	endtask : cyc

	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic key;
		pins.key = 1'b1;
		cyc(4);
		pins.key = 1'b0;
		cyc(4);
	endtask : key

	task automatic t_sense;
		pins.trig = 1'b1;
		cyc(12);
		chk("drives", 4'hf, drv);
		sok = 1'b0;
		cyc(6);
		// a short recovery must restart the qualifying time
		sok = 1'b1;
		cyc(3);
		sok = 1'b0;
		cyc(6);
		chk("drives", 4'hf, drv);
		cyc(8);
		chk("drives", 4'h0, drv);
		sok = 1'b1;
		cyc(30);
		chk("drives", 4'h0, drv);
		pins.trig = 1'b0;
		cyc(8);
		pins.trig = 1'b1;
		cyc(12);
		chk("drives", 4'hf, drv);
		pins.trig = 1'b0;
		cyc(8);
	endtask : t_sense

	task automatic t_ovl;
		pins.trig = 1'b1;
		cyc(12);
		pins.ovl = 1'b1;
		cyc(1);
		pins.ovl = 1'b0;
		cyc(5);
		chk("wfs disp", {FFS_DC_HOLD, 10'h01e}, dw);
		chk("volt code", FFS_DC_BLANK, dv.code);
		chk("drives", 4'h0, drv);
		cyc(16);
		chk("wfs disp", {FFS_DC_HOLD, 10'h01d}, dw);
		for (n = 0; n < 600 && dw.code === FFS_DC_HOLD; n++) cyc(1);
		chk("hold time", 1'b1, n > 450 && n < 470);
		chk("wfs code", FFS_DC_NUM, dw.code);
		pins.trig = 1'b0;
		cyc(8);
	endtask : t_ovl

	task automatic t_gnd;
		pins.trig = 1'b1;
		cyc(12);
		pins.gnd = 1'b1;
		cyc(1);
		pins.gnd = 1'b0;
		cyc(6);
		chk("wfs code", FFS_DC_GLP, dw.code);
		chk("volt code", FFS_DC_BLANK, dv.code);
		chk("drives", 4'h0, drv);
		key();
		chk("wfs code", FFS_DC_GLP, dw.code);
		pins.trig = 1'b0;
		cyc(6);
		key();
		chk("wfs code", FFS_DC_NUM, dw.code);
		pins.gnd = 1'b1;
		cyc(1);
		pins.gnd = 1'b0;
		cyc(6);
		pins.trig = 1'b1;
		cyc(12);
		chk("wfs code", FFS_DC_NUM, dw.code);
		chk("drives", 4'hf, drv);
		pins.trig = 1'b0;
		cyc(8);
	endtask : t_gnd

	task automatic t_disp;
		acc_setup = 1'b1;
		acc_set = 3'h7;
		cyc(3);
		chk("volt code", FFS_DC_ACC, dv.code);
		chk("acc val", 10'h005, dw.val);
		acc_set = 3'h0;
		cyc(3);
		chk("acc val", 10'h001, dw.val);
		acc_setup = 1'b0;
		timer_show = 1'b1;
		tval = 10'h02d;
		cyc(3);
		chk("wfs code", FFS_DC_SEC, dw.code);
		chk("volt disp", {FFS_DC_NUM, 10'h02d}, dv);
		timer_show = 1'b0;
		for (int i = 0; i < 3; i++) begin
			cf = 3'h1 << i;
			cyc(6);
			chk("volt code", FFS_DC_CLD, dv.code);
			chk("motor", cf[1:0], {mr, mf});
			chk("ps trig", 1'b0, pst);
			cf = 3'h0;
			cyc(3);
		end
		// cold mode with the trigger closed feeds wire but keeps weld output off
		cf = 3'h4;
		pins.trig = 1'b1;
		cyc(12);
		chk("motor", 2'h1, {mr, mf});
		chk("ps enable", 1'b0, pse);
		cf = 3'h1;
		cyc(3);
		chk("ps enable", 1'b0, pse);
		chk("volt code", FFS_DC_CLD, dv.code);
		pins.trig = 1'b0;
		cyc(4);
		cf = 3'h0;
		cyc(4);
		nv_bad = 1'b1;
		nv_chk = 1'b1;
		cyc(1);
		nv_chk = 1'b0;
		nv_bad = 1'b0;
		cyc(3);
		chk("err shown", 1'b1, dw.code === FFS_DC_ERR || dv.code === FFS_DC_ERR);
		key();
		chk("err shown", 1'b0, dw.code === FFS_DC_ERR || dv.code === FFS_DC_ERR);
	endtask : t_disp

	task automatic t_run;
		rphase = 1'b1;
		rmatch = 1'b1;
		cyc(3);
		chk("cmd", {10'h0c8, 10'h12c}, {cv, cw});
		wv = 10'h0b4;
		ww = 10'h0fa;
		cyc(3);
		chk("cmd", {10'h0b4, 10'h0fa}, {cv, cw});
		rmatch = 1'b0;
		cyc(3);
		chk("cmd", {10'h0a0, 10'h064}, {cv, cw});
		rv = 10'h08c;
		rw = 10'h050;
		cyc(3);
		chk("cmd", {10'h08c, 10'h050}, {cv, cw});
		rphase = 1'b0;
		pflow = 8'h02;
		pins.trig = 1'b1;
		cyc(12);
		pins.trig = 1'b0;
		cyc(20);
		chk("gas", 1'b1, gas);
		cyc(20);
		chk("gas", 1'b0, gas);
		pflow = 8'h00;
	endtask : t_run

	task automatic complete_run;
		if (bad_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run

	// whole sequence needs about 800 cycles
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		cyc(10);
		nrst_i = 1'b1;
		cyc(3);
		t_sense();
		t_ovl();
		t_gnd();
		t_disp();
		t_run();
		complete_run();
	end
endmodule : tb
`default_nettype wire
